/* File: agp_defines.svh */
// Purpose: register offsets, field positions and reset values of the gpio block
// Assumes: byte addresses on a 32-bit apb data bus, one aligned word per register
// Notes: per-port registers sit at base + 4 * port
`ifndef AGP_DEFINES_SVH
`define AGP_DEFINES_SVH

`define AGP_DIR_BASE 12'h000
`define AGP_MASK_BASE 12'h040
`define AGP_PIN_BASE 12'h080
`define AGP_MPIN_BASE 12'h0c0
`define AGP_SET_BASE 12'h100
`define AGP_CLR_BASE 12'h140
`define AGP_PSEL_BASE 12'h200
`define AGP_PCFG_ADDR 12'h220
`define AGP_GRP_BASE 12'h280
`define AGP_GCTRL_ADDR 12'h300
`define AGP_IST_ADDR 12'h304
`define AGP_IMSK_ADDR 12'h308

`define AGP_PCFG_MODE_LSB 0
`define AGP_PCFG_POL_LSB 8
`define AGP_IRQ_GRP_LSB 8

`define AGP_DIR_RST 32'h0000_0000
`define AGP_OUT_RST 32'h0000_0000
`define AGP_MASK_RST 32'h0000_0000
`define AGP_SEL_RST 8'h00
`define AGP_CFG_RST 16'h0000
`define AGP_IMSK_RST 10'h000

`endif

/* File: agp_pkg.sv */
// Purpose: shared types of the gpio block
// Assumes: at most eight ports of at most 31 pins
// Notes: offsets and reset values live in agp_defines.svh
`default_nettype none
package agp_pkg;
	localparam int NSLOT = 8;
	localparam int NGRP = 2;
	localparam int NEVT = NSLOT + NGRP;
	typedef struct packed {
		logic [2:0] port;
		logic [4:0] pin;
	} agp_sel_t;
	typedef struct packed {
		logic [NSLOT-1:0] pol;
		logic [NSLOT-1:0] level;
	} agp_pcfg_t;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} agp_apb_req_t;
endpackage : agp_pkg
`default_nettype wire

/* File: agp_gpio.sv */
// Purpose: accelerated gpio ports with pin interrupts and group interrupts
// Assumes: single clock core_clk, synchronous active-low reset nrst, apb slave
// Notes: pad inputs pass three sampling flip-flops and a filter flip-flop; pin buffer enables come from the pin config block
`include "agp_defines.svh"
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - There are eight independent ports, each with at most 31 pins.
// - Every pin has its own direction bit; a write replaces the bits of all pins in the written lanes of the port.
// - Separate set and clear locations drive written-one bits high or low and keep zero bits.
// - Software reads the output latch and the live pin level as separate values.
// - After reset all pins are inputs, with pull-up on and input buffer off in the pin config.
// - A per-port mask restricts masked reads and writes to the selected bits.
// - Every register accepts byte, halfword and word accesses on the addressed lanes only.
// - One word write to a port value location updates the whole port output at once.
// - Any eight pins can be routed to interrupt slots, each edge or level sensitive.
// - Two group units raise a request when selected pins meet their condition.
// - Port registers answer on the apb bus with no wait states.
module agp_gpio #(
	parameter int NPORTS = 8,
	parameter int NPINS = 31
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire agp_pkg::agp_apb_req_t apbReq,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NPORTS-1:0][NPINS-1:0] pinIn,
	input wire logic [NPORTS-1:0][NPINS-1:0] inBufEn,
	output logic [NPORTS-1:0][NPINS-1:0] pinOut,
	output logic [NPORTS-1:0][NPINS-1:0] pinOe,
	output logic irq
);
	import agp_pkg::*;

	// block bases as vectors so that their upper bits can be selected
	localparam logic [11:0] baseDir = `AGP_DIR_BASE;
	localparam logic [11:0] baseMask = `AGP_MASK_BASE;
	localparam logic [11:0] basePin = `AGP_PIN_BASE;
	localparam logic [11:0] baseMpin = `AGP_MPIN_BASE;
	localparam logic [11:0] baseSet = `AGP_SET_BASE;
	localparam logic [11:0] baseClr = `AGP_CLR_BASE;
	localparam logic [11:0] basePsel = `AGP_PSEL_BASE;
	localparam logic [11:0] baseGrp = `AGP_GRP_BASE;

	if (NPORTS < 1 || NPORTS > 8 || NPINS < 1 || NPINS > 31) begin : gBadGeom
		$error("agp_gpio: NPORTS must be 1..8 and NPINS 1..31");
	end

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	logic setupPh;
	logic accessPh;
	logic wrAcc;
	logic [11:0] adr;
	logic [2:0] aPort;
	logic portOk;
	logic [31:0] laneM;
	logic [31:0] wd;
	logic [31:0] rdD;
	logic errD;
	logic [31:0] rd_q;
	logic err_q;
	logic [NEVT-1:0] snap_q;

	assign adr = {apbReq.paddr[11:2], 2'b00};
	assign aPort = apbReq.paddr[4:2];
	assign portOk = (32'(aPort) < NPORTS);
	assign setupPh = apbReq.psel & ~apbReq.penable;
	assign accessPh = apbReq.psel & apbReq.penable;
	assign wrAcc = accessPh & apbReq.pwrite & ~err_q;
	assign laneM = {{8{apbReq.pstrb[3]}}, {8{apbReq.pstrb[2]}},
		{8{apbReq.pstrb[1]}}, {8{apbReq.pstrb[0]}}};
	assign wd = apbReq.pwdata & laneM;

	// ------------------------------------------------------------
	// port state
	// ------------------------------------------------------------
	logic [NPORTS-1:0][NPINS-1:0] dir_q;
	logic [NPORTS-1:0][NPINS-1:0] out_q;
	logic [NPORTS-1:0][NPINS-1:0] mask_q;
	logic [NPORTS-1:0][NPINS-1:0] s1_q;
	logic [NPORTS-1:0][NPINS-1:0] s2_q;
	logic [NPORTS-1:0][NPINS-1:0] s3_q;
	logic [NPORTS-1:0][NPINS-1:0] stable_q;
	logic [NPORTS-1:0][NPINS-1:0] live;
	agp_sel_t [NSLOT-1:0] sel_q;
	agp_pcfg_t pcfg_q;
	logic [NGRP-1:0][NPORTS-1:0][NPINS-1:0] gEna_q;
	logic [NGRP-1:0][NPORTS-1:0][NPINS-1:0] gPol_q;
	logic [NGRP-1:0] gAnd_q;
	logic [NEVT-1:0] ist_q;
	logic [NEVT-1:0] imsk_q;

	function automatic logic [NPINS-1:0] lanes(input logic [31:0] v);
		lanes = v[NPINS-1:0];
	endfunction : lanes

	// ------------------------------------------------------------
	// pad sampling
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			stable_q <= '0;
		end else begin
			s1_q <= pinIn;
			s2_q <= s1_q;
			s3_q <= s2_q;
			stable_q <= (s2_q & s3_q) | (stable_q & (s2_q ^ s3_q));
		end
	end
	assign live = stable_q & inBufEn;

	// ------------------------------------------------------------
	// direction, mask and output latch
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			dir_q <= {NPORTS{NPINS'(`AGP_DIR_RST)}};
			mask_q <= {NPORTS{NPINS'(`AGP_MASK_RST)}};
		end else if (wrAcc && portOk) begin
			if (adr[11:5] == baseDir[11:5]) begin
				dir_q[aPort] <= (dir_q[aPort] & ~lanes(laneM)) | lanes(wd);
			end else if (adr[11:5] == baseMask[11:5]) begin
				mask_q[aPort] <= (mask_q[aPort] & ~lanes(laneM)) | lanes(wd);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			out_q <= {NPORTS{NPINS'(`AGP_OUT_RST)}};
		end else if (wrAcc && portOk) begin
			if (adr[11:5] == basePin[11:5]) begin
				out_q[aPort] <= (out_q[aPort] & ~lanes(laneM)) | lanes(wd);
			end else if (adr[11:5] == baseMpin[11:5]) begin
				out_q[aPort] <= (out_q[aPort] & ~(lanes(laneM) & mask_q[aPort]))
					| (lanes(wd) & mask_q[aPort]);
			end else if (adr[11:5] == baseSet[11:5]) begin
				out_q[aPort] <= out_q[aPort] | lanes(wd);
			end else if (adr[11:5] == baseClr[11:5]) begin
				out_q[aPort] <= out_q[aPort] & ~lanes(wd);
			end
		end
	end

	assign pinOut = out_q;
	assign pinOe = dir_q;

	// ------------------------------------------------------------
	// interrupt configuration
	// ------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			sel_q <= {NSLOT{`AGP_SEL_RST}};
			pcfg_q <= `AGP_CFG_RST;
			gEna_q <= '0;
			gPol_q <= '0;
			gAnd_q <= '0;
			imsk_q <= `AGP_IMSK_RST;
		end else if (wrAcc) begin
			if (adr[11:5] == basePsel[11:5]) begin
				if (apbReq.pstrb[0]) begin
					sel_q[apbReq.paddr[4:2]] <= apbReq.pwdata[7:0];
				end
			end else if (adr == `AGP_PCFG_ADDR) begin
				if (apbReq.pstrb[0]) begin
					pcfg_q.level <= apbReq.pwdata[`AGP_PCFG_MODE_LSB +: NSLOT];
				end
				if (apbReq.pstrb[1]) begin
					pcfg_q.pol <= apbReq.pwdata[`AGP_PCFG_POL_LSB +: NSLOT];
				end
			end else if (adr[11:7] == baseGrp[11:7] && portOk) begin
				if (apbReq.paddr[5]) begin
					gPol_q[apbReq.paddr[6]][aPort] <= (gPol_q[apbReq.paddr[6]][aPort]
						& ~lanes(laneM)) | lanes(wd);
				end else begin
					gEna_q[apbReq.paddr[6]][aPort] <= (gEna_q[apbReq.paddr[6]][aPort]
						& ~lanes(laneM)) | lanes(wd);
				end
			end else if (adr == `AGP_GCTRL_ADDR) begin
				if (apbReq.pstrb[0]) begin
					gAnd_q <= apbReq.pwdata[NGRP-1:0];
				end
			end else if (adr == `AGP_IMSK_ADDR) begin
				if (apbReq.pstrb[0]) begin
					imsk_q[7:0] <= apbReq.pwdata[7:0];
				end
				if (apbReq.pstrb[1]) begin
					imsk_q[NEVT-1:8] <= apbReq.pwdata[NEVT-1:8];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// pin and group events
	// ------------------------------------------------------------
	logic [NSLOT-1:0] slotAct;
	logic [NSLOT-1:0] slotPrev_q;
	logic [NGRP-1:0] grpCond;
	logic [NGRP-1:0] grpPrev_q;
	logic [NEVT-1:0] evSet;
	logic [NEVT-1:0] clrM;

	always_comb begin
		for (int i = 0; i < NSLOT; i++) begin
			// polarity chooses high or rising, else low or falling
			slotAct[i] = 1'b0;
			if (32'(sel_q[i].port) < NPORTS && 32'(sel_q[i].pin) < NPINS) begin
				slotAct[i] = ~(live[sel_q[i].port][sel_q[i].pin] ^ pcfg_q.pol[i]);
			end
		end
	end

	always_comb begin
		for (int g = 0; g < NGRP; g++) begin
			// and or or across enabled pins
			if (gAnd_q[g]) begin
				grpCond[g] = (gEna_q[g] != '0)
					&& ((~(live ^ gPol_q[g]) & gEna_q[g]) == gEna_q[g]);
			end else begin
				grpCond[g] = ((~(live ^ gPol_q[g]) & gEna_q[g]) != '0);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			// idle slots read active after reset: no false edge on release
			slotPrev_q <= '1;
			grpPrev_q <= '0;
		end else begin
			slotPrev_q <= slotAct;
			grpPrev_q <= grpCond;
		end
	end

	assign evSet = {grpCond & ~grpPrev_q, slotAct & ~slotPrev_q};
	assign clrM = (accessPh && !apbReq.pwrite && adr == `AGP_IST_ADDR) ? snap_q : '0;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ist_q <= '0;
		end else begin
			// sticky bits except level-mode slots, which follow slotAct: a new event beats the read clear
			ist_q <= (ist_q & ~clrM) | evSet;
			for (int i = 0; i < NSLOT; i++) begin
				if (pcfg_q.level[i]) begin
					ist_q[i] <= slotAct[i];
				end
			end
		end
	end

	assign irq = |(ist_q & imsk_q);

	// ------------------------------------------------------------
	// read path
	// ------------------------------------------------------------
	always_comb begin
		rdD = '0;
		errD = 1'b0;
		if (adr[11:5] == baseDir[11:5] && portOk) begin
			rdD[NPINS-1:0] = dir_q[aPort];
		end else if (adr[11:5] == baseMask[11:5] && portOk) begin
			rdD[NPINS-1:0] = mask_q[aPort];
		end else if (adr[11:5] == basePin[11:5] && portOk) begin
			rdD[NPINS-1:0] = live[aPort];
		end else if (adr[11:5] == baseMpin[11:5] && portOk) begin
			rdD[NPINS-1:0] = live[aPort] & mask_q[aPort];
		end else if (adr[11:5] == baseSet[11:5] && portOk) begin
			rdD[NPINS-1:0] = out_q[aPort];
		end else if (adr[11:5] == baseClr[11:5] && portOk) begin
			rdD = '0;
		end else if (adr[11:5] == basePsel[11:5]) begin
			rdD[7:0] = sel_q[apbReq.paddr[4:2]];
		end else if (adr == `AGP_PCFG_ADDR) begin
			rdD[15:0] = pcfg_q;
		end else if (adr[11:7] == baseGrp[11:7] && portOk) begin
			rdD[NPINS-1:0] = apbReq.paddr[5] ? gPol_q[apbReq.paddr[6]][aPort]
				: gEna_q[apbReq.paddr[6]][aPort];
		end else if (adr == `AGP_GCTRL_ADDR) begin
			rdD[NGRP-1:0] = gAnd_q;
		end else if (adr == `AGP_IST_ADDR) begin
			rdD[NEVT-1:0] = ist_q;
		end else if (adr == `AGP_IMSK_ADDR) begin
			rdD[NEVT-1:0] = imsk_q;
		end else begin
			errD = 1'b1;
		end
	end

	// data latched in setup, answered in the first access cycle
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			rd_q <= '0;
			err_q <= 1'b0;
			snap_q <= '0;
		end else if (setupPh) begin
			rd_q <= rdD;
			err_q <= errD;
			snap_q <= ist_q;
		end
	end

	assign pready = 1'b1;
	assign prdata = rd_q;
	assign pslverr = accessPh & err_q;
endmodule : agp_gpio
`default_nettype wire

/* File: agp_gpio_props.sv */
// Purpose: bus and pin properties of the gpio block
// Assumes: zero-wait apb, writes land at the access edge
// Notes: bound to every agp_gpio instance
`timescale 1ns/10ps
`default_nettype none
module agp_gpio_props #(
	parameter int NPORTS = 8,
	parameter int NPINS = 31
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire agp_pkg::agp_apb_req_t apbReq,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [NPORTS-1:0][NPINS-1:0] pinIn,
	input wire logic [NPORTS-1:0][NPINS-1:0] inBufEn,
	input wire logic [NPORTS-1:0][NPINS-1:0] pinOut,
	input wire logic [NPORTS-1:0][NPINS-1:0] pinOe,
	input wire logic irq
);
	import agp_pkg::*;
	logic acc;
	logic wAcc;
	logic [2:0] pIx;
	logic [5:0] blk;
	logic [NPINS-1:0] wBits;
	logic [NPINS-1:0] curOut;
	assign acc = apbReq.psel && apbReq.penable && apbReq.pwrite && !apbReq.paddr[5];
	assign wAcc = acc && apbReq.pstrb == 4'hf;
	assign pIx = apbReq.paddr[4:2];
	assign blk = apbReq.paddr[11:6];
	assign wBits = apbReq.pwdata[NPINS-1:0];
	assign curOut = pinOut[pIx];
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence s_acc;
		apbReq.psel && !apbReq.penable ##1 apbReq.psel && apbReq.penable;
	endsequence
	a_ready_access: assert property (s_acc |-> pready)
		else $error("pready low in access");
	a_reset_io: assert property (disable iff (1'h0) !nrst |=> pinOe == '0 && irq == 1'h0)
		else $error("pins not inputs after reset");
	a_set_bits: assert property (wAcc && blk == 6'h04 |=> pinOut[$past(pIx)] == ($past(curOut) | $past(wBits)))
		else $error("set write wrong");
	a_clr_bits: assert property (wAcc && blk == 6'h05 |=> pinOut[$past(pIx)] == ($past(curOut) & ~$past(wBits)))
		else $error("clear write wrong");
	a_dir_word: assert property (wAcc && blk == 6'h00 |=> pinOe[$past(pIx)] == $past(wBits))
		else $error("direction write wrong");
	a_pin_word: assert property (wAcc && blk == 6'h02 |=> pinOut[$past(pIx)] == $past(wBits))
		else $error("port value write wrong");
	a_lane_only: assert property (acc && apbReq.pstrb == 4'h1 && blk == 6'h02 |=>
		pinOut[$past(pIx)] == {$past(curOut[NPINS-1:8]), $past(wBits[7:0])})
		else $error("byte write touched other lanes");
	a_idle_hold: assert property (!(apbReq.psel && apbReq.penable && apbReq.pwrite) |=> $stable(pinOut) && $stable(pinOe))
		else $error("pins changed without a write");
endmodule : agp_gpio_props
bind agp_gpio agp_gpio_props #(.NPORTS(NPORTS), .NPINS(NPINS)) props_u (.core_clk(core_clk),
	.nrst(nrst), .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pinIn(pinIn), .inBufEn(inBufEn), .pinOut(pinOut), .pinOe(pinOe), .irq(irq));
`default_nettype wire

/* File: agp_board.sv */
// Purpose: board circuitry on the gpio pads
// Assumes: pull-up on every pad, optional external driver
// Notes: a pad driven by the device shows its output latch
`timescale 1ns/10ps
`default_nettype none
module agp_board #(
	parameter int NPORTS = 8,
	parameter int NPINS = 31
) (
	input wire logic [NPORTS-1:0][NPINS-1:0] pinOut,
	input wire logic [NPORTS-1:0][NPINS-1:0] pinOe,
	input wire logic [NPORTS-1:0][NPINS-1:0] extVal,
	input wire logic [NPORTS-1:0][NPINS-1:0] extEn,
	output logic [NPORTS-1:0][NPINS-1:0] pinIn
);
	assign pinIn = (pinOe & pinOut) | (~pinOe & extEn & extVal) | (~pinOe & ~extEn);
endmodule : agp_board
`default_nettype wire

/* File: test_accelerated_gpio_ports.sv */
// Purpose: regression of the gpio block
// Assumes: zero-wait apb, board model on the pads
// Notes: one task per bus access
`timescale 1ns/10ps
`default_nettype none
module test_accelerated_gpio_ports;
	import agp_pkg::*;
	logic core_clk = 1'h0;
	logic nrst = 1'h0;
	agp_apb_req_t req = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic [7:0][30:0] pinIn;
	logic [7:0][30:0] pinOut;
	logic [7:0][30:0] pinOe;
	logic [7:0][30:0] inBufEn = '0;
	logic [7:0][30:0] extVal = '0;
	logic [7:0][30:0] extEn = '0;
	int err_count = 0;
	int checks = 0;
	int cyc = 0;
	logic [31:0] rd;
	logic err;
	always #5 core_clk = ~core_clk;
	agp_gpio dut_u (.core_clk(core_clk), .nrst(nrst), .apbReq(req), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pinIn(pinIn), .inBufEn(inBufEn),
		.pinOut(pinOut), .pinOe(pinOe), .irq(irq));
	agp_board brd_u (.pinOut(pinOut), .pinOe(pinOe), .extVal(extVal), .extEn(extEn),
		.pinIn(pinIn));
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge core_clk);
		req <= '{1'h1, 1'h0, w, a, d, s};
		@(posedge core_clk);
		req.penable <= 1'h1;
		@(posedge core_clk);
		while (pready !== 1'h1) @(posedge core_clk);
		rd = prdata;
		err = pslverr;
		req.psel <= 1'h0;
		req.penable <= 1'h0;
		@(negedge core_clk);
	endtask : xfer
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(a, 1'h1, d, 4'hf);
	endtask : wr
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		xfer(a, 1'h0, 32'h0, 4'hf);
		cmp($sformatf("reg %h", a), e, rd);
	endtask : rdc
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			final_report();
		end
	end
	initial begin
		repeat (10) @(posedge core_clk);
		nrst <= 1'h1;
		for (int p = 0; p < 8; p++) rdc(12'(4 * p), 32'h0);
		cmp("oe", 32'h0, {31'h0, |pinOe});
		rdc(12'h080, 32'h0);
		$display("test reset done");
		wr(12'h004, 32'h5);
		cmp("oe1", 32'h5, {1'h0, pinOe[1]});
		cmp("oe2", 32'h0, {1'h0, pinOe[2]});
		wr(12'h108, 32'hf);
		wr(12'h148, 32'h3);
		cmp("out2", 32'hc, {1'h0, pinOut[2]});
		rdc(12'h108, 32'hc);
		wr(12'h08c, 32'h72345678);
		cmp("out3", 32'h72345678, {1'h0, pinOut[3]});
		xfer(12'h08c, 1'h1, 32'h0000ab00, 4'h2);
		xfer(12'h08c, 1'h1, 32'h11110000, 4'hc);
		cmp("out3b", 32'h1111ab78, {1'h0, pinOut[3]});
		xfer(12'h08c, 1'h1, 32'h000000cd, 4'h1);
		cmp("out3c", 32'h1111abcd, {1'h0, pinOut[3]});
		wr(12'h040, 32'hff);
		wr(12'h0c0, 32'hffffffff);
		cmp("out0", 32'hff, {1'h0, pinOut[0]});
		$display("test outputs done");
		@(posedge core_clk);
		inBufEn[0] <= '1;
		extEn[0][4] <= 1'h1;
		repeat (6) @(negedge core_clk);
		rdc(12'h080, 32'h7fffffef);
		rdc(12'h0c0, 32'h000000ef);
		$display("test inputs done");
		wr(12'h200, 32'h04);
		wr(12'h220, 32'h100);
		wr(12'h2a0, 32'h10);
		wr(12'h280, 32'h10);
		// drop whatever routing itself latched before unmasking
		xfer(12'h304, 1'h0, 32'h0, 4'hf);
		wr(12'h308, 32'h101);
		repeat (2) @(negedge core_clk);
		cmp("irq0", 32'h0, {31'h0, irq});
		@(posedge core_clk);
		extVal[0][4] <= 1'h1;
		repeat (8) @(negedge core_clk);
		cmp("irq", 32'h1, {31'h0, irq});
		rdc(12'h304, 32'h101);
		rdc(12'h304, 32'h0);
		wr(12'h220, 32'h101);
		rdc(12'h304, 32'h1);
		rdc(12'h304, 32'h1);
		wr(12'h300, 32'h1);
		rdc(12'h300, 32'h1);
		wr(12'h308, 32'h0);
		repeat (2) @(negedge core_clk);
		cmp("irqm", 32'h0, {31'h0, irq});
		$display("test interrupts done");
		xfer(12'h3fc, 1'h0, 32'h0, 4'hf);
		cmp("err", 32'h1, {31'h0, err});
		cmp("rd0", 32'h0, rd);
		$display("test unmapped done");
		final_report();
	end
endmodule : test_accelerated_gpio_ports
`default_nettype wire
